/* File: pwp_bridge.sv */
`timescale 1ns/1ps
// Contract
// - Writing zero leaves protection bit unchanged.
// - Writing one clears that peripheral's protection.
// - Read returns one while protected.
// - Clear register at offset zero, resets 0x000002.
// - Bits 6,3,2,1 implemented; others reserved.
// - Bridge is bus slave reaching peripheral registers.
// - Peripheral side follows APB4 incl. wait, error.
// - Address and data in one merged cycle.
// - Byte, half, word lanes, reads included.
module pwp_bridge (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic hsel,
  input wire logic [pwp_pkg::ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [3:0] hprot,
  input wire logic [pwp_pkg::DATA_W-1:0] hwdata,
  input wire logic hready,
  output logic [pwp_pkg::DATA_W-1:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic psel,
  output logic penable,
  output logic [pwp_pkg::ADDR_W-1:0] paddr,
  output logic pwrite,
  output logic [pwp_pkg::DATA_W-1:0] pwdata,
  output logic [pwp_pkg::STRB_W-1:0] pstrb,
  output logic [2:0] pprot,
  input wire logic [pwp_pkg::DATA_W-1:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  output logic [pwp_pkg::DATA_W-1:0] protectState
);

  // ****************************************
  // Functions
  // ****************************************
  // Lane strobes for a transfer size and low address bits.
  function automatic logic [pwp_pkg::STRB_W-1:0] laneStrobe(
    input logic [2:0] size,
    input logic [1:0] addrLow
  );
    logic [pwp_pkg::STRB_W-1:0] base;
    base = pwp_pkg::STRB_NONE;
    unique case (size)
      pwp_pkg::SIZE_BYTE: base = pwp_pkg::STRB_BYTE;
      pwp_pkg::SIZE_HALF: base = pwp_pkg::STRB_HALF;
      pwp_pkg::SIZE_WORD: base = pwp_pkg::STRB_WORD;
      default: base = pwp_pkg::STRB_NONE;
    endcase
    return base << addrLow;
  endfunction : laneStrobe

  // Expands lane strobes into a bit mask.
  function automatic logic [pwp_pkg::DATA_W-1:0] laneMask(
    input logic [pwp_pkg::STRB_W-1:0] strb
  );
    logic [pwp_pkg::DATA_W-1:0] mask;
    mask = '0;
    for (int i = 0; i < pwp_pkg::STRB_W; i++) begin
      mask[i*8 +: 8] = {8{strb[i]}};
    end
    return mask;
  endfunction : laneMask

  // ****************************************
  // Reset release
  // ****************************************
  logic rstMeta_ff;
  logic rstSync_ff;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rstMeta_ff <= 1'b0;
      rstSync_ff <= 1'b0;
    end else begin
      rstMeta_ff <= 1'b1;
      rstSync_ff <= rstMeta_ff;
    end
  end

  wire logic rst_n = rstSync_ff;

  // ****************************************
  // Request capture
  // ****************************************
  pwp_pkg::pwp_state_t state_ff;
  pwp_pkg::pwp_state_t nxt_state;
  logic [pwp_pkg::ADDR_W-1:0] addr_ff;
  logic write_ff;
  logic [2:0] size_ff;
  logic [3:0] prot_ff;
  logic [pwp_pkg::DATA_W-1:0] protect_ff;
  logic [pwp_pkg::DATA_W-1:0] hrdata_ff;
  logic [pwp_pkg::DATA_W-1:0] pwdata_ff;
  logic [pwp_pkg::STRB_W-1:0] pstrb_ff;

  logic accept;
  logic [pwp_pkg::SLOT_W-1:0] slot;
  logic bankHit;
  logic slotLocked;
  logic [pwp_pkg::STRB_W-1:0] curStrb;

  assign hreadyout = (state_ff == pwp_pkg::PWP_IDLE) || (state_ff == pwp_pkg::PWP_DONE)
    || (state_ff == pwp_pkg::PWP_ERR2);
  assign hresp = (state_ff == pwp_pkg::PWP_ERR1) || (state_ff == pwp_pkg::PWP_ERR2);
  assign accept = hsel && hready && (htrans == pwp_pkg::TRANS_NONSEQ || htrans[1]);
  assign slot = addr_ff[pwp_pkg::SLOT_LSB +: pwp_pkg::SLOT_W];
  assign bankHit = (slot == pwp_pkg::BANK_SLOT);
  assign slotLocked = protect_ff[slot] && write_ff && !bankHit;
  assign curStrb = laneStrobe(size_ff, addr_ff[1:0]);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      addr_ff <= '0;
      write_ff <= 1'b0;
      size_ff <= pwp_pkg::SIZE_WORD;
      prot_ff <= '0;
    end else if (accept) begin
      addr_ff <= haddr;
      write_ff <= hwrite;
      size_ff <= hsize;
      prot_ff <= hprot;
    end
  end

  // ****************************************
  // Transfer sequencer
  // ****************************************
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      pwp_pkg::PWP_IDLE, pwp_pkg::PWP_DONE, pwp_pkg::PWP_ERR2: begin
        nxt_state = accept ? pwp_pkg::PWP_LATCH : pwp_pkg::PWP_IDLE;
      end
      pwp_pkg::PWP_LATCH: begin
        if (slotLocked) begin
          nxt_state = pwp_pkg::PWP_ERR1;
        end else if (bankHit) begin
          nxt_state = pwp_pkg::PWP_DONE;
        end else begin
          nxt_state = pwp_pkg::PWP_ACCESS;
        end
      end
      pwp_pkg::PWP_ACCESS: begin
        if (pready) begin
          nxt_state = pslverr ? pwp_pkg::PWP_ERR1 : pwp_pkg::PWP_DONE;
        end
      end
      pwp_pkg::PWP_ERR1: begin
        nxt_state = pwp_pkg::PWP_ERR2;
      end
      default: begin
        nxt_state = pwp_pkg::PWP_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= pwp_pkg::PWP_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ****************************************
  // Peripheral side outputs
  // ****************************************
  assign psel = (state_ff == pwp_pkg::PWP_ACCESS);
  assign penable = (state_ff == pwp_pkg::PWP_ACCESS);
  assign paddr = addr_ff;
  assign pwrite = write_ff;
  assign pwdata = pwdata_ff;
  assign pstrb = pstrb_ff;
  assign pprot = {~prot_ff[0], 1'b0, prot_ff[1]};

  // Write data and lanes are held stable for the whole access.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pwdata_ff <= '0;
      pstrb_ff <= pwp_pkg::STRB_NONE;
    end else if (state_ff == pwp_pkg::PWP_LATCH) begin
      pwdata_ff <= hwdata;
      pstrb_ff <= curStrb;
    end
  end

  // ****************************************
  // Protection bank and read data
  // ****************************************
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      protect_ff <= pwp_pkg::PROTECT_RESET;
    end else if (state_ff == pwp_pkg::PWP_LATCH && bankHit && write_ff
                 && addr_ff[7:2] == pwp_pkg::PROTECT_CLEAR_OFFSET[7:2]) begin
      // Only ones within the written lanes clear; zeros keep the state.
      protect_ff <= protect_ff & ~(hwdata & laneMask(curStrb) & pwp_pkg::PROTECT_IMPL_MASK);
    end
  end

  assign protectState = protect_ff;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      hrdata_ff <= '0;
    end else if (state_ff == pwp_pkg::PWP_LATCH && bankHit) begin
      hrdata_ff <= protect_ff & pwp_pkg::PROTECT_IMPL_MASK & laneMask(curStrb);
    end else if (state_ff == pwp_pkg::PWP_ACCESS && pready) begin
      hrdata_ff <= prdata & laneMask(pstrb_ff);
    end
  end

  assign hrdata = hrdata_ff;

endmodule : pwp_bridge

/* File: pwp_pkg.sv */
package pwp_pkg;

  // ****************************************
  // Bus widths and address map
  // ****************************************
  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;
  localparam int STRB_W = 4;
  localparam int SLOT_LSB = 8;
  localparam int SLOT_W = 5;
  localparam logic [SLOT_W-1:0] BANK_SLOT = 5'h00;
  localparam logic [7:0] PROTECT_CLEAR_OFFSET = 8'h00;

  // ****************************************
  // Protection bank layout
  // ****************************************
  localparam logic [DATA_W-1:0] PROTECT_RESET = 32'h00000002;
  localparam int TRACE_BUFFER_BIT = 6;
  localparam int PIN_PORT_BIT = 3;
  localparam int NVM_CONTROLLER_BIT = 2;
  localparam int SERVICE_UNIT_BIT = 1;
  localparam logic [DATA_W-1:0] PROTECT_IMPL_MASK = 32'h0000004e;

  // ****************************************
  // Transfer encodings
  // ****************************************
  localparam logic [1:0] TRANS_NONSEQ = 2'h2;
  localparam logic [2:0] SIZE_BYTE = 3'h0;
  localparam logic [2:0] SIZE_HALF = 3'h1;
  localparam logic [2:0] SIZE_WORD = 3'h2;
  localparam logic [STRB_W-1:0] STRB_BYTE = 4'h1;
  localparam logic [STRB_W-1:0] STRB_HALF = 4'h3;
  localparam logic [STRB_W-1:0] STRB_WORD = 4'hf;
  localparam logic [STRB_W-1:0] STRB_NONE = 4'h0;

  // ****************************************
  // Bridge states
  // ****************************************
  typedef enum logic [2:0] {
    PWP_IDLE = 3'h0,
    PWP_LATCH = 3'h1,
    PWP_ACCESS = 3'h3,
    PWP_DONE = 3'h2,
    PWP_ERR1 = 3'h6,
    PWP_ERR2 = 3'h7
  } pwp_state_t;

endpackage : pwp_pkg

/* File: pwp_props.sv */
`timescale 1ns/1ps
module pwp_props (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic psel,
  input wire logic penable,
  input wire logic [pwp_pkg::STRB_W-1:0] pstrb,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [pwp_pkg::DATA_W-1:0] protectState
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);
  a_merged_cycle: assert property (psel == penable)
    else $error("select and enable differ");
  a_slverr_maps: assert property (psel && pready && pslverr |=> hresp && !hreadyout)
    else $error("slave error not passed on");
  a_access_ends: assert property (psel && pready && !pslverr |=> !psel && hreadyout && !hresp)
    else $error("access did not end cleanly");
  a_wait_holds: assert property (psel && !pready |=> psel && $stable(pstrb))
    else $error("access dropped during wait");
  a_error_pair: assert property ($rose(hresp) |-> !hreadyout ##1 hresp && hreadyout)
    else $error("error response not two cycles");
  a_only_clears: assert property ((protectState & ~$past(protectState)) == 32'h0)
    else $error("protection bit got set");
  a_reserved_zero: assert property ((protectState & ~pwp_pkg::PROTECT_IMPL_MASK) == 32'h0)
    else $error("reserved protection bit set");
  a_strobe_set: assert property (psel |-> pstrb != 4'h0)
    else $error("access without lanes");
  cover property (hresp && hreadyout);
  cover property (psel && !pready);
  cover property ($fell(protectState[1]));
endmodule : pwp_props

/* File: pwp_apb_peer.sv */
`timescale 1ns/1ps
module pwp_apb_peer (
  input wire logic mclk,
  input wire logic psel,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [1:0] waitN,
  input wire logic errOn,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [31:0] store
);
  logic [1:0] cnt_ff = 2'h0;
  logic [31:0] mem_ff = 32'h5a5a0f0f;
  always_ff @(posedge mclk) cnt_ff <= (psel && !pready) ? cnt_ff + 2'h1 : 2'h0;
  always_ff @(posedge mclk) begin
    for (int i = 0; i < 4; i++) begin
      if (pready && pwrite && !errOn && pstrb[i]) mem_ff[8*i+:8] <= pwdata[8*i+:8];
    end
  end
  assign pready = psel && cnt_ff == waitN;
  assign pslverr = pready && errOn;
  assign prdata = psel ? mem_ff : ~mem_ff;
  assign store = mem_ff;
endmodule : pwp_apb_peer

/* File: test_peripheral_write_protect.sv */
`timescale 1ns/1ps
module test_peripheral_write_protect;
  logic mclk, arst_n, hsel, hwrite, hreadyout, hresp, psel, penable, pwrite;
  logic pready, pslverr, errOn, rsp;
  logic [1:0] htrans, waitN;
  logic [2:0] hsize, pprot;
  logic [3:0] pstrb, hprot;
  logic [31:0] haddr, hwdata, hrdata, paddr, pwdata, prdata, protectState, store, rd;
  int fail_count = 0;
  int n_tests = 0;
  int lat;
  pwp_bridge uut (.mclk, .arst_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hprot,
    .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .psel, .penable, .paddr, .pwrite,
    .pwdata, .pstrb, .pprot, .prdata, .pready, .pslverr, .protectState);
  pwp_apb_peer peer (.mclk, .psel, .pwrite, .pwdata, .pstrb, .waitN, .errOn, .prdata,
    .pready, .pslverr, .store);
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task test_done;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : test_done
  // One bus transfer; the answer is read at the falling edge where it is settled.
  task xfer(input logic wr, input logic [31:0] a, input logic [2:0] sz, input logic [31:0] d);
    hsel = 1'b1;
    htrans = 2'h2;
    hwrite = wr;
    haddr = a;
    hsize = sz;
    @(posedge mclk);
    #1;
    hsel = 1'b0;
    htrans = 2'h0;
    hwdata = d;
    lat = 0;
    do begin
      @(negedge mclk);
      lat++;
    end while (hreadyout !== 1'b1 && lat < 20);
    if (lat >= 20) begin
      fail_count++;
      test_done();
    end
    rd = hrdata;
    rsp = hresp;
    @(posedge mclk);
    #1;
  endtask : xfer
  initial begin
    arst_n = 1'b0;
    hsel = 1'b0;
    htrans = 2'h0;
    hwrite = 1'b0;
    haddr = 32'h0;
    hsize = 3'h0;
    hwdata = 32'h0;
    waitN = 2'h0;
    errOn = 1'b0;
    hprot = 4'h3;
    repeat (4) @(posedge mclk);
    #1;
    arst_n = 1'b1;
    repeat (3) @(posedge mclk);
    #1;
    chk("protect reset", 32'h2, protectState);
    xfer(1'b0, 32'h0, 3'h2, 32'h0);
    chk("bank read", 32'h2, rd);
    chk("bank latency", 2, lat);
    xfer(1'b1, 32'h100, 3'h2, 32'h12345678);
    chk("locked resp", 1, rsp);
    chk("locked store", 32'h5a5a0f0f, store);
    $display("reset and lock test done");
    xfer(1'b1, 32'h0, 3'h2, 32'hffffff00);
    xfer(1'b1, 32'h1, 3'h0, 32'h0000ff02);
    chk("zero write", 32'h2, protectState);
    xfer(1'b1, 32'h0, 3'h2, 32'h2);
    chk("one write", 32'h0, protectState);
    xfer(1'b0, 32'h0, 3'h2, 32'h0);
    chk("cleared read", 32'h0, rd);
    $display("clear test done");
    xfer(1'b1, 32'h100, 3'h2, 32'h12345678);
    chk("open store", 32'h12345678, store);
    chk("open latency", 3, lat);
    chk("open prot", 32'h1, pprot);
    xfer(1'b1, 32'h403, 3'h0, 32'hab000000);
    chk("byte store", 32'hab345678, store);
    chk("byte lanes", 32'h8, pstrb);
    chk("byte addr", 32'h403, paddr);
    chk("byte data", 32'hab000000, pwdata);
    chk("byte dir", 1, pwrite);
    waitN = 2'h2;
    hprot = 4'h0;
    xfer(1'b0, 32'h402, 3'h1, 32'h0);
    chk("half read", 32'hab340000, rd);
    chk("wait latency", 5, lat);
    chk("half lanes", 32'hc, pstrb);
    chk("half prot", 32'h4, pprot);
    errOn = 1'b1;
    xfer(1'b0, 32'h400, 3'h2, 32'h0);
    chk("slave error", 1, rsp);
    $display("peripheral test done");
    arst_n = 1'b0;
    repeat (4) @(posedge mclk);
    #1;
    arst_n = 1'b1;
    repeat (3) @(posedge mclk);
    #1;
    chk("reset again", 32'h2, protectState);
    xfer(1'b1, 32'h100, 3'h2, 32'h0);
    chk("relocked resp", 1, rsp);
    chk("relocked store", 32'hab345678, store);
    $display("second reset test done");
    test_done();
  end
endmodule : test_peripheral_write_protect
bind pwp_bridge pwp_props chk_i (.mclk, .arst_n, .hreadyout, .hresp, .psel, .penable, .pstrb,
  .pready, .pslverr, .protectState);
